// [bench/lslm_line_model.sv]
// lslm_line_model: line supply and speed sensing stand-in
`timescale 1ns/10ps
`default_nettype none
module lslm_line_model (
  // clock
  input  wire logic        hclk,
  // requests from the bench
  input  wire logic [3:0]  ext_req_n,
  input  wire logic        uv_req,
  input  wire logic        ov_req,
  input  wire logic [11:0] fq_req,
  input  wire logic [15:0] sp_req,
  // measured values to the monitor
  output logic [3:0]       ext_event_n,
  output logic             uv_cond,
  output logic             ov_cond,
  output logic [11:0]      line_freq,
  output logic [15:0]      speed
);
  // one sample of measurement latency, like a real sensing path
  always_ff @(posedge hclk) begin
    {ext_event_n, uv_cond, ov_cond, line_freq, speed} <= {ext_req_n, uv_req, ov_req, fq_req, sp_req};
  end
endmodule // lslm_line_model
`default_nettype wire

// [bench/lslm_properties.sv]
// lslm_properties: port-level checks for the limit monitor
`timescale 1ns/10ps
`default_nettype none
module lslm_properties
  import lslm_pkg::*;
(
  // clock, reset and bus
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic       hready,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hreadyout,
  // measured inputs
  input wire logic [3:0] ext_event_n,
  input wire logic       uv_cond,
  input wire logic       ov_cond,
  // flags
  input wire logic [1:0] ext_fault,
  input wire logic [1:0] ext_alarm,
  input wire logic       line_undervoltage_fault,
  input wire logic       line_overvoltage_fault,
  input wire logic       underfrequency_fault,
  input wire logic       overfrequency_fault,
  input wire logic       wait_line_voltage_state,
  input wire logic       firing_enable
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // any fault level; alarms never block gating
  wire logic any_f = |{ext_fault, line_undervoltage_fault, line_overvoltage_fault,
                       underfrequency_fault, overfrequency_fault};
  // read request and its single wait cycle
  sequence rd_req; hsel && hready && htrans == HTRANS_NONSEQ && !hwrite; endsequence
  sequence rd_ans; !hreadyout ##1 hreadyout; endsequence
  read_wait_a: assert property (rd_req |=> rd_ans) else $error("read wait cycle wrong");
  ext_clear_a: assert property (ext_event_n[0] [*3] |-> !ext_fault[0]) else $error("fault without input");
  alarm_clear_a: assert property (ext_event_n[3] [*3] |-> !ext_alarm[1]) else $error("alarm without input");
  uv_clear_a: assert property (!uv_cond [*3] |-> !line_undervoltage_fault) else $error("uv fault stuck");
  ov_clear_a: assert property (!ov_cond [*3] |-> !line_overvoltage_fault) else $error("ov fault stuck");
  fire_on_a: assert property (!any_f ##1 !any_f |-> firing_enable) else $error("gating blocked");
  fire_off_a: assert property (any_f && $past(any_f) |-> !firing_enable) else $error("gating on in fault");
  wait_uv_a: assert property (uv_cond |=> wait_line_voltage_state) else $error("no wait on uv");
  under_wait_a: assert property ($rose(underfrequency_fault) |-> wait_line_voltage_state) else $error("uf");
  over_wait_a: assert property ($rose(overfrequency_fault) |-> wait_line_voltage_state) else $error("of");
endmodule // lslm_properties
bind lslm_top lslm_properties chk_u (.hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .hreadyout,
  .ext_event_n, .uv_cond, .ov_cond, .ext_fault, .ext_alarm, .line_undervoltage_fault, .line_overvoltage_fault,
  .underfrequency_fault, .overfrequency_fault, .wait_line_voltage_state, .firing_enable);
`default_nettype wire

// [bench/lslm_top_bench.sv]
// lslm_top_bench: self-checking bench for the limit monitor
`timescale 1ns/10ps
`default_nettype none
module lslm_top_bench;
  import lslm_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, uv_req, ov_req, uv_cond, ov_cond;
  logic uvf, ovf, ufq, ofq, wait_s, fire, lows, cmps;
  logic [1:0] htrans, ext_fault, ext_alarm;
  logic [3:0] ext_req_n, ext_event_n;
  logic [11:0] haddr, fq_req, line_freq;
  logic [15:0] sp_req, speed;
  logic [31:0] hwdata, hrdata, rd;
  int fails, total_checks, cyc;
  // short time base keeps millisecond delays to ten cycles
  lslm_top #(.TICK_DIV(10)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_event_n, .uv_cond, .ov_cond, .line_freq, .speed,
    .ext_fault, .ext_alarm, .line_undervoltage_fault(uvf), .line_overvoltage_fault(ovf),
    .underfrequency_fault(ufq), .overfrequency_fault(ofq), .wait_line_voltage_state(wait_s),
    .firing_enable(fire), .low_speed(lows), .compare_speed(cmps), .irq);
  lslm_line_model line_u (.hclk, .ext_req_n, .uv_req, .ov_req, .fq_req, .sp_req, .ext_event_n, .uv_cond,
    .ov_cond, .line_freq, .speed);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic end_sim;
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single ahb transfer; read data lands in rd
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic t_defaults;
    bus(1'b0, ADDR_CFG0, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 12'h1C4, 32'h0);
    chk(rd, 32'h2710);
    bus(1'b0, 12'h080, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
  endtask
  task automatic t_ext;
    bus(1'b1, ADDR_DEB0, 32'h3);
    ext_req_n <= 4'h6;
    wt(12);
    chk({ext_fault, ext_alarm}, 4'h2);
    wt(30);
    chk({ext_fault, ext_alarm}, 4'h6);
    ext_req_n <= 4'hF;
    wt(5);
  endtask
  task automatic t_uv;
    bus(1'b1, ADDR_CFG0, 32'h5);
    bus(1'b1, ADDR_RESTART, 32'h5);
    bus(1'b1, ADDR_MASK, 32'h10);
    bus(1'b1, ADDR_STATUS, 32'hFF);
    uv_req <= 1'b1;
    wt(45);
    chk({uvf, fire, wait_s}, 3'h3);
    wt(20);
    chk(uvf, 1'b0);
    wt(45);
    chk({uvf, fire, irq}, 3'h5);
    uv_req <= 1'b0;
    wt(5);
    chk({uvf, irq}, 2'h1);
    bus(1'b1, ADDR_STATUS, 32'h10);
    // clear lands at the edge that ends the write; look one edge later
    wt(1);
    chk(irq, 1'b0);
  endtask
  task automatic t_line;
    bus(1'b1, ADDR_RESTART, 32'h2);
    bus(1'b1, ADDR_CFG0 + 12'h004, 32'h2);
    ov_req <= 1'b1;
    wt(50);
    chk(ovf, 1'b1);
    ov_req <= 1'b0;
    fq_req <= 12'h190;
    wt(5);
    chk({ufq, wait_s}, 2'h1);
    wt(30);
    chk({ufq, fire}, 2'h2);
    fq_req <= 12'h2BC;
    wt(35);
    chk({ofq, ufq, wait_s}, 3'h5);
    fq_req <= 12'h1F4;
    wt(5);
    chk({ofq, wait_s}, 2'h0);
  endtask
  task automatic t_cmp;
    bus(1'b1, ADDR_CFG0 + 12'h020, 32'h1);
    chk(cmps, 1'b1);
    sp_req <= 16'h27D8;
    wt(1200);
    chk(cmps, 1'b1);
    sp_req <= 16'h28A0;
    wt(500);
    chk(cmps, 1'b1);
    wt(600);
    chk(cmps, 1'b0);
    sp_req <= 16'h2706;
    wt(4);
    chk(cmps, 1'b1);
  endtask
  task automatic t_low;
    sp_req <= 16'h0028;
    wt(4);
    chk(lows, 1'b1);
    sp_req <= 16'h005A;
    wt(4);
    chk(lows, 1'b1);
    sp_req <= 16'h0065;
    wt(4);
    chk(lows, 1'b0);
    bus(1'b1, 12'h150, 32'h3E8);
    bus(1'b1, ADDR_CTRL, 32'h1);
    wt(4);
    chk(lows, 1'b1);
  endtask
  initial begin
    {hresetn, hsel, hwrite, uv_req, ov_req, haddr, htrans, hwdata} = '0;
    {fails, total_checks, cyc} = '0;
    ext_req_n = 4'hF;
    fq_req = 12'h1F4;
    sp_req = 16'h1388;
    wt(3);
    hresetn <= 1'b1;
    wt(1);
    t_defaults;
    t_ext;
    t_uv;
    t_line;
    t_cmp;
    t_low;
    end_sim;
  end
endmodule // lslm_top_bench
`default_nettype wire

// [core/lslm_delay.sv]
// lslm_delay: on-delay counter in time base ticks
`timescale 1ns/10ps
`default_nettype none

module lslm_delay #(
  parameter int unsigned W = 17                 // counter width
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // control
  input  wire logic         tick,               // 1 ms enable pulse
  input  wire logic         run,                // condition present
  input  wire logic [W-1:0] limit,              // delay in ticks
  // result
  output logic              done                // delay elapsed, condition held
);

  // counter state
  typedef struct packed {
    logic [W-1:0] cnt;                          // ticks seen while running
    logic         done;                         // expired flag
  } lslm_dly_s;

  lslm_dly_s st_r;                              // registered state
  lslm_dly_s st_nxt;                            // next state

  // count ticks while run holds; any drop restarts from zero
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = '0;
      st_nxt.done = 1'b0;
    end else if (st_r.cnt >= limit) begin
      // saturate: counter stops once expired
      st_nxt.done = 1'b1;
    end else if (tick) begin
      st_nxt.cnt = st_r.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;

endmodule // lslm_delay

`default_nettype wire

// [core/lslm_pkg.sv]
// lslm_pkg: shared constants for the line and speed limit monitor
package lslm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 20;             // hclk period
  localparam int unsigned TICK_PERIOD_MS = 1;             // time base step
  localparam int unsigned NS_PER_MS = 1000000;            // unit conversion
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 17;                   // delay counter width
  localparam logic [TIMER_W-1:0] TICKS_PER_TENTH = 17'h00064; // 100 ms in ticks

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned NUM_SETS = 4;                   // indexed data sets
  localparam int unsigned NUM_CFG = 9;                    // settings per set
  localparam int unsigned NUM_EXT = 4;                    // external events
  localparam int unsigned NUM_EVT = 8;                    // status bits

  ////////////////////////////////////////////////////////////////////////////
  // setting slots inside one data set
  localparam int unsigned CFG_UV_DELAY = 0;               // undervoltage_trip_delay, ms
  localparam int unsigned CFG_OV_DELAY = 1;               // overvoltage_trip_delay, ms
  localparam int unsigned CFG_FMIN = 2;                   // min_line_frequency, 0.1 Hz
  localparam int unsigned CFG_FMAX = 3;                   // max_line_frequency, 0.1 Hz
  localparam int unsigned CFG_NMIN = 4;                   // low_speed_threshold, 0.01 %
  localparam int unsigned CFG_NMIN_HYST = 5;              // low_speed_hysteresis
  localparam int unsigned CFG_NCMP = 6;                   // compare_speed_threshold
  localparam int unsigned CFG_NCMP_HYST = 7;              // compare_speed_hysteresis
  localparam int unsigned CFG_NCMP_OFF = 8;               // compare_speed_off_delay, 0.1 s

  // reset values of one data set, slot 8 first
  localparam logic [NUM_CFG-1:0][15:0] CFG_DEFAULT = {
    16'h001E,   // off delay 3.0 s
    16'h012C,   // compare hysteresis 3.00 %
    16'h2710,   // compare threshold 100.00 %
    16'h0032,   // low speed hysteresis 0.50 %
    16'h0032,   // low speed threshold 0.50 %
    16'h028A,   // max frequency 65.0 Hz
    16'h01C2,   // min frequency 45.0 Hz
    16'h2710,   // overvoltage delay 10000 ms
    16'h0000    // undervoltage delay 0 ms
  };
  localparam logic [15:0] DEF_DEBOUNCE = 16'h0000;        // external delays 0 ms
  localparam logic [15:0] DEF_RESTART = 16'h0000;         // auto_restart_time, ms

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;            // active data set
  localparam logic [11:0] ADDR_STATUS = 12'h004;          // sticky events, w1c
  localparam logic [11:0] ADDR_MASK = 12'h008;            // interrupt mask
  localparam logic [11:0] ADDR_LIVE = 12'h00C;            // live flags
  localparam logic [11:0] ADDR_DEB0 = 12'h010;            // four debounce delays
  localparam logic [11:0] ADDR_RESTART = 12'h020;         // restart time
  localparam logic [11:0] ADDR_CFG0 = 12'h100;            // data set 0 slot 0
  localparam logic [11:0] CFG_SET_STRIDE = 12'h040;       // bytes per data set

  ////////////////////////////////////////////////////////////////////////////
  // status / mask / live bit positions
  localparam int unsigned EVT_EXT_F1 = 0;
  localparam int unsigned EVT_EXT_F2 = 1;
  localparam int unsigned EVT_EXT_A1 = 2;
  localparam int unsigned EVT_EXT_A2 = 3;
  localparam int unsigned EVT_UV = 4;
  localparam int unsigned EVT_OV = 5;
  localparam int unsigned EVT_UF = 6;
  localparam int unsigned EVT_OF = 7;
  localparam int unsigned LIVE_LOW_SPEED = 8;
  localparam int unsigned LIVE_CMP_SPEED = 9;
  localparam int unsigned LIVE_WAIT = 10;
  localparam int unsigned LIVE_FIRE = 11;

  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : lslm_pkg

// [core/lslm_top.sv]
// lslm_top: line and speed limit monitor with ahb-lite registers
//
// Contract
// (R1) external events raised after low for delay
// (R2) undervoltage fault delayed, default zero
// (R3) overvoltage fault delayed, default 10000 ms
// (R4) firing stays enabled during trip delays
// (R5) restart timer starts after trip delay
// (R6) underfrequency fault after restart time
// (R7) hold waiting state while frequency low
// (R8) overfrequency fault after restart time
// (R9) hold waiting state while frequency high
// (R10) low speed signal with added hysteresis
// (R11) low speed feeds stop and brake sequencing
// (R12) compare speed signal with added hysteresis
// (R13) compare speed release held by off delay
// (R14) four data sets, selected one applies
// (R15) hold waiting state during undervoltage
// (R16) one millisecond tick drives all delays
`timescale 1ns/10ps
`default_nettype none

module lslm_top
  import lslm_pkg::*;
#(
  parameter int unsigned TICK_DIV = lslm_pkg::TICK_CYCLES  // hclk cycles per 1 ms
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // measured quantities
  input  wire logic [3:0]  ext_event_n,     // fault1, fault2, alarm1, alarm2, active low
  input  wire logic        uv_cond,         // line below undervoltage threshold
  input  wire logic        ov_cond,         // line above overvoltage threshold
  input  wire logic [11:0] line_freq,       // line frequency, 0.1 Hz units
  input  wire logic [15:0] speed,           // speed magnitude, 0.01 % units
  // fault and alarm flags
  output logic [1:0]       ext_fault,
  output logic [1:0]       ext_alarm,
  output logic             line_undervoltage_fault,
  output logic             line_overvoltage_fault,
  output logic             underfrequency_fault,
  output logic             overfrequency_fault,
  // sequencing
  output logic             wait_line_voltage_state,  // hold drive before run
  output logic             firing_enable,            // gating allowed
  output logic             low_speed,                // speed below minimum
  output logic             compare_speed,            // speed below compare level
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [NUM_SETS-1:0][NUM_CFG-1:0][15:0] cfg;    // indexed settings
    logic [NUM_EXT-1:0][15:0]               deb;    // external delays
    logic [15:0]                            restart; // restart time
    logic [1:0]                             ds;     // active data set
    logic [NUM_EVT-1:0]                     status; // sticky events
    logic [NUM_EVT-1:0]                     mask;   // interrupt mask
    logic [NUM_EVT-1:0]                     flt;    // live fault levels
    logic [15:0]                            div;    // tick divider
    logic                                   tick;   // 1 ms pulse
    logic                                   ph_valid; // data phase pending
    logic                                   ph_write; // pending is write
    logic [11:0]                            ph_addr;  // pending address
    logic                                   hreadyout;
    logic [31:0]                            hrdata;
    logic                                   irq;
    logic                                   low_speed;
    logic                                   cmp_raw;  // compare before off delay
    logic                                   cmp_out;  // compare after off delay
    logic                                   wait_st;
    logic                                   fire_en;
  } lslm_st_s;

  lslm_st_s st_r;                           // registered state
  lslm_st_s st_nxt;                         // next state

  // timer outputs
  logic [NUM_EXT-1:0] deb_done;             // external debounce expired
  logic               uv_dly_done;          // undervoltage delay expired
  logic               ov_dly_done;          // overvoltage delay expired
  logic               uv_rst_done;          // undervoltage restart expired
  logic               ov_rst_done;          // overvoltage restart expired
  logic               uf_rst_done;          // underfrequency restart expired
  logic               of_rst_done;          // overfrequency restart expired
  logic               off_done;             // compare off delay expired

  // active data set view
  logic [NUM_CFG-1:0][15:0] act;            // settings in use
  logic                     freq_low;       // below minimum frequency
  logic                     freq_high;      // above maximum frequency
  logic [TIMER_W-1:0]       off_limit;      // off delay in ticks

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // widen a 16-bit setting to the timer width
  function automatic logic [TIMER_W-1:0] to_ticks(input logic [15:0] v);
    to_ticks = {{(TIMER_W-16){1'b0}}, v};
  endfunction

  // below-threshold comparator; hysteresis widens release while active
  function automatic logic below_hyst(input logic        active,
                                      input logic [15:0] val,
                                      input logic [15:0] thr,
                                      input logic [15:0] hyst);
    logic [16:0] rel;
    rel = {1'b0, thr} + {1'b0, hyst};
    if (active) begin
      // stay active until speed climbs above threshold plus hysteresis
      below_hyst = ({1'b0, val} <= rel);
    end else begin
      below_hyst = (val < thr);
    end
  endfunction

  // register read decode
  function automatic logic [31:0] read_reg(input lslm_st_s s, input logic [11:0] a);
    logic [11:0] off;
    read_reg = 32'h0000_0000;
    off = a - ADDR_CFG0;
    if (a == ADDR_CTRL) begin
      read_reg = {30'h0000_0000, s.ds};
    end else if (a == ADDR_STATUS) begin
      read_reg = {24'h00_0000, s.status};
    end else if (a == ADDR_MASK) begin
      read_reg = {24'h00_0000, s.mask};
    end else if (a == ADDR_LIVE) begin
      read_reg = {20'h0_0000, s.fire_en, s.wait_st, s.cmp_out, s.low_speed, s.flt};
    end else if (a >= ADDR_DEB0 && a < ADDR_RESTART) begin
      read_reg = {16'h0000, s.deb[a[3:2]]};
    end else if (a == ADDR_RESTART) begin
      read_reg = {16'h0000, s.restart};
    end else if (a >= ADDR_CFG0 && off[5:2] < 4'(NUM_CFG) && off[11:8] == 4'h0) begin
      read_reg = {16'h0000, s.cfg[off[7:6]][off[5:2]]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // delay timers

  // (R14) selected data set applies
  assign act = st_r.cfg[st_r.ds];

  assign freq_low = (line_freq < act[CFG_FMIN][11:0]);
  assign freq_high = (line_freq > act[CFG_FMAX][11:0]);

  // (R13) off delay counted in tenths
  assign off_limit = to_ticks(act[CFG_NCMP_OFF]) * TICKS_PER_TENTH;

  // one debounce per external input, each with its own delay
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_deb
      // (R1) low held for own delay
      lslm_delay #(.W(TIMER_W)) u_deb (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (st_r.tick),
        .run     (!ext_event_n[gi]),
        .limit   (to_ticks(st_r.deb[gi])),
        .done    (deb_done[gi])
      );
    end
  endgenerate

  // (R2) undervoltage trip delay
  lslm_delay #(.W(TIMER_W)) u_uv_dly (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (st_r.tick),
    .run     (uv_cond),
    .limit   (to_ticks(act[CFG_UV_DELAY])),
    .done    (uv_dly_done)
  );

  // (R3) overvoltage trip delay
  lslm_delay #(.W(TIMER_W)) u_ov_dly (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (st_r.tick),
    .run     (ov_cond),
    .limit   (to_ticks(act[CFG_OV_DELAY])),
    .done    (ov_dly_done)
  );

  // (R5) restart timer gated by trip delay
  lslm_delay #(.W(TIMER_W)) u_uv_rst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (st_r.tick),
    .run     (uv_cond && uv_dly_done),
    .limit   (to_ticks(st_r.restart)),
    .done    (uv_rst_done)
  );

  // (R5) same sequencing for overvoltage
  lslm_delay #(.W(TIMER_W)) u_ov_rst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (st_r.tick),
    .run     (ov_cond && ov_dly_done),
    .limit   (to_ticks(st_r.restart)),
    .done    (ov_rst_done)
  );

  // (R6) underfrequency restart window
  lslm_delay #(.W(TIMER_W)) u_uf_rst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (st_r.tick),
    .run     (freq_low),
    .limit   (to_ticks(st_r.restart)),
    .done    (uf_rst_done)
  );

  // (R8) overfrequency restart window
  lslm_delay #(.W(TIMER_W)) u_of_rst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (st_r.tick),
    .run     (freq_high),
    .limit   (to_ticks(st_r.restart)),
    .done    (of_rst_done)
  );

  // (R13) release delay of compare signal
  lslm_delay #(.W(TIMER_W)) u_off (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (st_r.tick),
    .run     (st_r.cmp_out && !st_r.cmp_raw),
    .limit   (off_limit),
    .done    (off_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [11:0] off;                       // offset into settings window
    logic [NUM_EVT-1:0] w1c;                // bits software clears
    logic [NUM_EVT-1:0] rise;               // new fault edges
    st_nxt = st_r;
    off = st_r.ph_addr - ADDR_CFG0;
    w1c = '0;
    rise = '0;

    // (R16) millisecond tick divider
    st_nxt.tick = 1'b0;
    if (st_r.div >= 16'(TICK_DIV - 1)) begin
      st_nxt.div = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.div = st_r.div + 16'h0001;
    end

    // ahb address phase capture; only a granted, selected nonseq starts one
    st_nxt.ph_valid = 1'b0;
    if (st_r.ph_valid && !st_r.ph_write) begin
      // read wait state over: present data now
      st_nxt.hrdata = read_reg(st_r, st_r.ph_addr);
      st_nxt.hreadyout = 1'b1;
    end else if (st_r.ph_valid && st_r.ph_write) begin
      // write data phase: hwdata is valid this cycle
      if (st_r.ph_addr == ADDR_CTRL) begin
        st_nxt.ds = hwdata[1:0];
      end else if (st_r.ph_addr == ADDR_STATUS) begin
        w1c = hwdata[NUM_EVT-1:0];
      end else if (st_r.ph_addr == ADDR_MASK) begin
        st_nxt.mask = hwdata[NUM_EVT-1:0];
      end else if (st_r.ph_addr >= ADDR_DEB0 && st_r.ph_addr < ADDR_RESTART) begin
        st_nxt.deb[st_r.ph_addr[3:2]] = hwdata[15:0];
      end else if (st_r.ph_addr == ADDR_RESTART) begin
        st_nxt.restart = hwdata[15:0];
      end else if (st_r.ph_addr >= ADDR_CFG0 && off[5:2] < 4'(NUM_CFG) && off[11:8] == 4'h0) begin
        // (R14) each data set has its own copy
        st_nxt.cfg[off[7:6]][off[5:2]] = hwdata[15:0];
      end
      // unmapped writes fall through and are dropped
    end
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      st_nxt.ph_valid = 1'b1;
      st_nxt.ph_write = hwrite;
      st_nxt.ph_addr = {haddr[11:2], 2'b00};
      // reads take one wait state so hrdata can come from a flop
      st_nxt.hreadyout = hwrite;
    end

    // fault levels, registered once more for clean outputs
    st_nxt.flt[EVT_EXT_F1] = deb_done[0];
    st_nxt.flt[EVT_EXT_F2] = deb_done[1];
    st_nxt.flt[EVT_EXT_A1] = deb_done[2];
    st_nxt.flt[EVT_EXT_A2] = deb_done[3];
    st_nxt.flt[EVT_UV] = uv_rst_done;
    st_nxt.flt[EVT_OV] = ov_rst_done;
    // (R6) frequency still low after restart time
    st_nxt.flt[EVT_UF] = uf_rst_done;
    // (R8) frequency still high after restart time
    st_nxt.flt[EVT_OF] = of_rst_done;

    // sticky status: a new event beats a same-cycle clear
    rise = st_nxt.flt & ~st_r.flt;
    st_nxt.status = (st_r.status & ~w1c) | rise;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);

    // (R4) only an expired fault blocks gating
    st_nxt.fire_en = !(st_nxt.flt[EVT_UV] || st_nxt.flt[EVT_OV] ||
                       st_nxt.flt[EVT_UF] || st_nxt.flt[EVT_OF] ||
                       st_nxt.flt[EVT_EXT_F1] || st_nxt.flt[EVT_EXT_F2]);

    // (R7) (R9) (R15) hold before run while frequency is out of range or voltage is low
    st_nxt.wait_st = freq_low || freq_high || uv_cond;

    // (R10) (R11) low speed for stop and brake logic
    st_nxt.low_speed = below_hyst(st_r.low_speed, speed, act[CFG_NMIN], act[CFG_NMIN_HYST]);

    // (R12) compare speed, raw comparator
    st_nxt.cmp_raw = below_hyst(st_r.cmp_out, speed, act[CFG_NCMP], act[CFG_NCMP_HYST]);

    // (R13) set at once, release after off delay
    if (st_r.cmp_raw) begin
      st_nxt.cmp_out = 1'b1;
    end else if (off_done) begin
      st_nxt.cmp_out = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.cfg <= {NUM_SETS{CFG_DEFAULT}};
      st_r.deb <= {NUM_EXT{DEF_DEBOUNCE}};
      st_r.restart <= DEF_RESTART;
      st_r.hreadyout <= 1'b1;
      st_r.fire_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all but the constant hresp straight from the state register

  assign hreadyout = st_r.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = st_r.hrdata;
  assign ext_fault = st_r.flt[EVT_EXT_F2:EVT_EXT_F1];
  assign ext_alarm = st_r.flt[EVT_EXT_A2:EVT_EXT_A1];
  assign line_undervoltage_fault = st_r.flt[EVT_UV];
  assign line_overvoltage_fault = st_r.flt[EVT_OV];
  assign underfrequency_fault = st_r.flt[EVT_UF];
  assign overfrequency_fault = st_r.flt[EVT_OF];
  assign wait_line_voltage_state = st_r.wait_st;
  assign firing_enable = st_r.fire_en;
  assign low_speed = st_r.low_speed;
  assign compare_speed = st_r.cmp_out;
  assign irq = st_r.irq;

endmodule // lslm_top

`default_nettype wire
